// *** src/irq_output_and_status.sv ***
// interrupt request output stage with configuration, status and enable registers
// assumes a single-cycle register port master and asynchronous pin/phy inputs
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "irq_map.svh"
module irq_output_and_status
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic second_phy_event,
  input wire logic xtal_clk,
  output logic irq_out,
  output logic irq_oe,
  output logic digital_reset_pulse
);
  irq_pkg::word_t pin_config;
  irq_pkg::word_t status;
  irq_pkg::word_t enable;
  irq_pkg::word_t next_status;
  irq_pkg::ready_state_e ready_state;
  irq_pkg::ready_state_e next_ready_state;
  logic [7:0] ready_count;
  logic phy_sync1;
  logic phy_sync2;
  logic xtal_sync1;
  logic xtal_sync2;
  logic soft_reset;
  logic master_irq;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  wire logic cfg_wr;
  wire logic sts_wr;
  wire logic en_wr;
  wire logic rst_wr;
  wire logic any_reset;
  wire logic ready_set;
  wire logic enabled_active;
  wire irq_pkg::word_t cfg_view;
  wire irq_pkg::word_t read_mux;
  wire irq_pkg::word_t w1c;

  assign cfg_wr = reg_write & hit(reg_addr, `PIN_CONFIG_OFFSET);
  assign sts_wr = reg_write & hit(reg_addr, `STATUS_OFFSET);
  assign en_wr = reg_write & hit(reg_addr, `ENABLE_OFFSET);
  assign rst_wr = reg_write & hit(reg_addr, `RESET_CONTROL_REG_OFFSET);
  assign any_reset = soft_reset;
  // writes of zero leave bits alone; only w1c positions take part
  assign w1c = sts_wr ? reg_wdata : 32'h0000_0000;
  assign ready_set = (ready_state == irq_pkg::st_wait) && (ready_count == 8'h00);
  assign enabled_active = |(status & enable);

  wire irq_pkg::word_t next_enable;
  wire logic [7:0] next_ready_count;
  wire logic next_soft_reset;
  wire irq_pkg::word_t next_rdata;
  wire irq_pkg::word_t next_pin_config;
  wire irq_pkg::word_t kept_config;

  assign next_enable = en_wr ? (reg_wdata & `ENABLE_RW_MASK) : enable;
  // the counter only runs while waiting and nonzero, so it holds at zero
  assign next_ready_count = (ready_state == irq_pkg::st_wait && ready_count != 8'h00)
                          ? ready_count - 8'h01 : ready_count;
  assign next_soft_reset = rst_wr & reg_wdata[`RST_DIGITAL_BIT];
  // read data is zero outside the answer cycle so a stale word is never seen
  assign next_rdata = reg_read ? read_mux : 32'h0000_0000;
  assign next_pin_config = cfg_wr ? (reg_wdata & `CFG_RW_MASK) : pin_config;
  assign kept_config = pin_config & 32'h0000_0001;
  // reads back the master flag, so readback tracks the request before the output enable gates it
  assign cfg_view = (pin_config & `CFG_RW_MASK)
                  | ({31'h0000_0000, master_irq} << `CFG_MASTER_BIT);
  assign read_mux = hit(reg_addr, `PIN_CONFIG_OFFSET) ? cfg_view :
                    hit(reg_addr, `STATUS_OFFSET) ? status :
                    hit(reg_addr, `ENABLE_OFFSET) ? (enable & `ENABLE_RW_MASK) :
                    32'h0000_0000;

  always_comb
  begin
    next_status = status;
    // clear first, then set, so a same-cycle event survives the ack
    next_status[`STS_SW_BIT] = status[`STS_SW_BIT] & ~w1c[`STS_SW_BIT];
    next_status[`STS_READY_BIT] = status[`STS_READY_BIT] & ~w1c[`STS_READY_BIT];
    if (en_wr && reg_wdata[`STS_SW_BIT])
      next_status[`STS_SW_BIT] = 1'b1;
    if (ready_set)
      next_status[`STS_READY_BIT] = 1'b1;
    next_status[`STS_PHYB_BIT] = phy_sync2;
  end

  always_comb
  begin
    next_ready_state = ready_state;
    case (ready_state)
      irq_pkg::st_reset: next_ready_state = irq_pkg::st_wait;
      irq_pkg::st_wait: if (ready_count == 8'h00) next_ready_state = irq_pkg::st_ready;
      irq_pkg::st_ready: next_ready_state = irq_pkg::st_ready;
      default: next_ready_state = irq_pkg::st_reset;
    endcase
  end

  // second phy event comes from another clock: two stages before any use
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      phy_sync1 <= 1'b0;
      phy_sync2 <= 1'b0;
    end
    else
    begin
      phy_sync1 <= second_phy_event;
      phy_sync2 <= phy_sync1;
    end
  end

  // the routed crystal clock is only as good as core_clk sampling allows
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_sync1 <= 1'b0;
      xtal_sync2 <= 1'b0;
    end
    else
    begin
      xtal_sync1 <= xtal_clk;
      xtal_sync2 <= xtal_sync1;
    end
  end

  // driver type survives the digital reset; only rst returns it to default
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_config <= `CFG_RESET;
    else if (any_reset)
      pin_config <= kept_config;
    else
      pin_config <= next_pin_config;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= `STATUS_RESET;
    else if (any_reset)
      status <= `STATUS_RESET;
    else
      status <= next_status;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      enable <= `ENABLE_RESET;
    else if (any_reset)
      enable <= `ENABLE_RESET;
    else
      enable <= next_enable;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ready_state <= irq_pkg::st_reset;
    else if (any_reset)
      ready_state <= irq_pkg::st_reset;
    else
      ready_state <= next_ready_state;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ready_count <= `READY_DELAY_COUNT;
    else if (any_reset)
      ready_count <= `READY_DELAY_COUNT;
    else
      ready_count <= next_ready_count;
  end

  // one cycle behind the status so the flag never sees half an update
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      master_irq <= 1'b0;
    else if (any_reset)
      master_irq <= 1'b0;
    else
      master_irq <= enabled_active;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      soft_reset <= 1'b0;
    else if (any_reset)
      soft_reset <= 1'b0;
    else
      soft_reset <= next_soft_reset;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= next_rdata;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      digital_reset_pulse <= 1'b0;
    else
      digital_reset_pulse <= soft_reset;
  end

  wire logic gated_request;
  // output enable masks only the pin; status and master flag are untouched
  assign gated_request = master_irq & pin_config[`CFG_EN_BIT];

  // software is expected to pick push-pull before clock output; not enforced
  irq_pin_driver u_driver
  (
    .core_clk(core_clk),
    .rst(rst),
    .request(gated_request),
    .push_pull(pin_config[`CFG_TYPE_BIT]),
    .request_polarity(pin_config[`CFG_POL_BIT]),
    .clock_select(pin_config[`CFG_CLKSEL_BIT]),
    .xtal_level(xtal_sync2),
    .pin_out(irq_out),
    .pin_oe(irq_oe)
  );
endmodule

// *** src/irq_map.svh ***
// register offsets, field positions and reset values of the interrupt pin block
// assumes word-addressed byte offsets on an 8-bit register port address
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
`define PIN_CONFIG_OFFSET 8'h54
`define STATUS_OFFSET 8'h58
`define ENABLE_OFFSET 8'h5C
`define RESET_CONTROL_REG_OFFSET 8'h60
`define CFG_TYPE_BIT 0
`define CFG_CLKSEL_BIT 1
`define CFG_POL_BIT 4
`define CFG_EN_BIT 8
`define CFG_MASTER_BIT 12
`define STS_SW_BIT 31
`define STS_READY_BIT 30
`define STS_PHYB_BIT 27
`define RST_DIGITAL_BIT 0
`define CFG_RESET 32'h0000_0000
`define STATUS_RESET 32'h0000_0000
`define ENABLE_RESET 32'h0000_0000
`define CFG_RW_MASK 32'h0000_0113
`define ENABLE_RW_MASK 32'hC800_0000
`define READY_DELAY_COUNT 8'h10
`endif

// *** src/irq_pkg.sv ***
// types shared by the interrupt pin block
// assumes nothing of its surroundings
package irq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_wait = 2'b01,
    st_ready = 2'b11
  } ready_state_e;
endpackage

// *** src/irq_pin_driver.sv ***
// request pin driver: polarity, driver type and debug clock routing
// assumes the xtal clock input is already a plain level on core_clk
`timescale 1ns/1ns
`include "irq_map.svh"
module irq_pin_driver
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic request,
  input wire logic push_pull,
  input wire logic request_polarity,
  input wire logic clock_select,
  input wire logic xtal_level,
  output logic pin_out,
  output logic pin_oe
);
  wire logic active_level;
  wire logic drive_value;
  wire logic drive_enable;
  // open-drain ignores polarity: low when active, released otherwise, while clock_select is off; with it on the routed xtal clock decides
  assign active_level = push_pull ? (request_polarity ? request : ~request) : 1'b0;
  // open-drain never drives a high level, even while the debug clock is routed out
  assign drive_value = push_pull ? (clock_select ? xtal_level : active_level) : 1'b0;
  // push-pull always drives; open-drain drives only when asserting, or while the routed xtal clock is low
  assign drive_enable = push_pull ? 1'b1 : (clock_select ? ~xtal_level : request);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= drive_value;
      pin_oe <= drive_enable;
    end
  end
endmodule

// *** bench/irq_properties.sv ***
// assertions on the register port and request pin of the interrupt block
// assumes single-cycle strobes and the offsets of irq_map.svh
`timescale 1ns/1ns
`include "irq_map.svh"
module irq_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic digital_reset_pulse
);
  logic [31:0] cfg_q;
  logic [1:0] quiet;
  wire cfg_wr = reg_write && reg_addr == `PIN_CONFIG_OFFSET;
  wire soft_wr = reg_write && reg_addr == `RESET_CONTROL_REG_OFFSET;
  wire cfg_rd = reg_read && reg_addr == `PIN_CONFIG_OFFSET;
  wire sts_rd = reg_read && reg_addr == `STATUS_OFFSET;
  wire map_rd = cfg_rd || sts_rd || reg_addr == `ENABLE_OFFSET;
  // pin checks wait until a config change has had time to reach the pin
  wire settled = quiet == 2'h3;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q <= '0;
      quiet <= '0;
    end
    else
    begin
      if (cfg_wr)
        cfg_q <= reg_wdata & `CFG_RW_MASK;
      else if (digital_reset_pulse)
        cfg_q <= cfg_q & 32'h0000_0001;
      if (cfg_wr || soft_wr || digital_reset_pulse)
        quiet <= '0;
      else if (!settled)
        quiet <= quiet + 2'h1;
    end
  end
  property p_unmapped;
    reg_read && !map_rd |=> reg_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  property p_sts_rsvd;
    sts_rd |=> (reg_rdata & ~`ENABLE_RW_MASK) == '0;
  endproperty
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("bad status bits");
  property p_cfg_rsvd;
    cfg_rd |=> (reg_rdata & ~32'h0000_1113) == '0;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("bad config bits");
  property p_open_drain;
    settled && !cfg_q[0] |-> !irq_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain high");
  property p_push_pull;
    settled && cfg_q[0] |-> irq_oe;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push pull idle");
  property p_disabled;
    settled && !cfg_q[8] && !cfg_q[1] |-> (cfg_q[0] ? irq_out == !cfg_q[4] : !irq_oe);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin active");
  property p_soft_reset;
    soft_wr && reg_wdata[0] |-> ##[1:3] digital_reset_pulse;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no soft reset");
  property p_pulse_once;
    digital_reset_pulse |=> !digital_reset_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("long reset pulse");
endmodule
bind irq_output_and_status irq_checker chk_u (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .irq_out, .irq_oe, .digital_reset_pulse);

// *** bench/host_irq_input.sv ***
// host interrupt input: a pull-up holds the line high while released
// assumes the pin output and enable of the interrupt block
`timescale 1ns/1ns
module host_irq_input
(
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic line
);
  assign line = pin_oe ? pin_out : 1'b1;
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the interrupt pin block
// assumes the host pin model beside it
`timescale 1ns/1ns
`include "irq_map.svh"
module testbench;
  logic core_clk = 0, rst = 1, reg_write = 0, reg_read = 0, phy = 0, xtal = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [39:0] seen;
  logic [11:0] cfgs [7] = '{12'h100, 12'h110, 12'h101, 12'h111, 12'h011, 12'h001, 12'h000};
  logic [1:0] pins [7] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1};
  wire [31:0] reg_rdata;
  wire irq_out, irq_oe, line;
  int failures = 0, check_count = 0;
  irq_output_and_status dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .second_phy_event(phy), .xtal_clk(xtal), .irq_out, .irq_oe,
    .digital_reset_pulse());
  host_irq_input host_u (.pin_out(irq_out), .pin_oe(irq_oe), .line);
  initial forever #4 core_clk = ~core_clk;
  initial forever #20 xtal = ~xtal;
  task automatic check(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  // pin latency is fixed: status, master flag, then pin register
  task automatic pin(input logic [1:0] exp);
    repeat (4) @(posedge core_clk);
    #1 check({30'h0, irq_oe, line}, {30'h0, exp});
    @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rd(`PIN_CONFIG_OFFSET, 32'h0000_0000);
    repeat (30) @(posedge core_clk);
    rd(`STATUS_OFFSET, 32'h4000_0000);
    wr(`STATUS_OFFSET, 32'h0000_0000);
    rd(`STATUS_OFFSET, 32'h4000_0000);
    wr(`STATUS_OFFSET, 32'hFFFF_FFFF);
    rd(`STATUS_OFFSET, 32'h0000_0000);
    wr(`ENABLE_OFFSET, 32'h8000_0000);
    rd(`STATUS_OFFSET, 32'h8000_0000);
    wr(`ENABLE_OFFSET, 32'h0000_0000);
    rd(`STATUS_OFFSET, 32'h8000_0000);
    wr(`STATUS_OFFSET, 32'h8000_0000);
    rd(`STATUS_OFFSET, 32'h0000_0000);
    $display("status test done");
    phy <= 1;
    repeat (4) @(posedge core_clk);
    rd(`STATUS_OFFSET, 32'h0800_0000);
    wr(`STATUS_OFFSET, 32'h0800_0000);
    rd(`STATUS_OFFSET, 32'h0800_0000);
    wr(`ENABLE_OFFSET, 32'h0800_0000);
    rd(`PIN_CONFIG_OFFSET, 32'h0000_1000);
    foreach (cfgs[i])
    begin
      wr(`PIN_CONFIG_OFFSET, {20'h0, cfgs[i]});
      pin(pins[i]);
    end
    $display("pin test done");
    wr(`PIN_CONFIG_OFFSET, 32'h0000_0001);
    wr(`PIN_CONFIG_OFFSET, 32'hFFFF_FFFF);
    rd(`PIN_CONFIG_OFFSET, 32'h0000_1113);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      #1 seen[i] = line;
    end
    check(32'(seen != '0 && seen != '1), 32'h1);
    wr(`RESET_CONTROL_REG_OFFSET, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    rd(`PIN_CONFIG_OFFSET, 32'h0000_0001);
    rd(`ENABLE_OFFSET, 32'h0000_0000);
    rd(8'h70, 32'h0000_0000);
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rd(`PIN_CONFIG_OFFSET, 32'h0000_0000);
    $display("reset test done");
    end_of_test;
  end
endmodule
